// ===== core/acal_params.svh
`ifndef ACAL_PARAMS_SVH
`define ACAL_PARAMS_SVH
// Operation
// - Timed run lasts 250, 500 or 1000 ms
// - Code 3: run until a cancellation trigger
// - After cancellation, take calibration measurements
// - Crossing window 100, 200, 300, 390 us
// - Duration selector resets to code 2

// ==========================================================
// Register offsets
`define ACAL_OFS_ZC         8'h29
`define ACAL_OFS_DUR        8'h2a
`define ACAL_OFS_CTRL       8'h2b

// ==========================================================
// Field positions
`define ACAL_SEL_LSB        0
`define ACAL_CTRL_GO        0
`define ACAL_CTRL_DONE      1
`define ACAL_CTRL_RUN       2
`define ACAL_CTRL_MEAS      3
`define ACAL_CTRL_MAN       4

// ==========================================================
// Reset values and codes
`define ACAL_DUR_RST        2'h2
`define ACAL_ZC_RST         2'h0
`define ACAL_DUR_MANUAL     2'h3

// ==========================================================
// Timing
`define ACAL_CLK_PERIOD_NS  10
`define ACAL_TICK_NS        1000
`define ACAL_TICK_CYC       (`ACAL_TICK_NS / `ACAL_CLK_PERIOD_NS)
`define ACAL_CAL0_MS        250
`define ACAL_CAL1_MS        500
`define ACAL_CAL2_MS        1000
`define ACAL_MEAS_MS        5
`define ACAL_MAN_MIN_S      1
`define ACAL_ZC0_US         100
`define ACAL_ZC1_US         200
`define ACAL_ZC2_US         300
`define ACAL_ZC3_US         390
`define ACAL_US_PER_MS      1000

`endif

// ===== core/acal_pkg.sv
package acal_pkg;

  // Calibration phases
  typedef enum logic [1:0] {
    ACAL_IDLE,
    ACAL_RUN,
    ACAL_MEAS
  } acal_phase_t;

  // State of the top module, apart from the reset release flops rst_meta_q and rstn_q and the count, busy and expiry flops inside the two timer instances
  typedef struct packed {
    acal_phase_t phase;
    logic        manual;
    logic [1:0]  dur;
    logic [1:0]  zc;
    logic        done;
    logic [7:0]  rdata;
    logic [2:0]  trig_s;
    logic [2:0]  en_s;
    logic        trig_l;
    logic        en_l;
    logic [15:0] div;
    logic        tick;
  } acal_state_t;

endpackage

// ===== core/acal_tick_timer.sv
`timescale 1ns/100ps
// Down counter advanced by a tick enable; expire is a one-cycle pulse
module acal_tick_timer #(
  parameter int unsigned CNT_W = 20
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Control
  input  wire logic             tick_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] load_val_in,
  // Status
  output logic                  busy_out,
  output logic                  expire_out
);
  import acal_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             exp;
  } acal_tmr_t;

  acal_tmr_t st_q;
  acal_tmr_t st_d;

  // Load wins over counting; expiry when the last tick is taken
  always_comb begin
    st_d     = st_q;
    st_d.exp = 1'b0;
    if (load_in) begin
      st_d.cnt = load_val_in;
    end else if (tick_in && (st_q.cnt != '0)) begin
      st_d.cnt = st_q.cnt - 1'b1;
      st_d.exp = (st_q.cnt == CNT_W'(1));
    end
    st_d.busy = (st_d.cnt != '0);
  end

  // State register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy_out   = st_q.busy;
  assign expire_out = st_q.exp;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // A loaded count of N expires after exactly N further ticks
  a_count_down: assert property (
    (!load_in && tick_in && st_q.cnt == CNT_W'(1))
      |=> (st_q.exp && !busy_out)
  ) else $error("timer did not expire on last tick");

endmodule

// ===== core/acal_top.sv
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "acal_params.svh"
// Calibration run timing and crossing-detect window timing
module acal_top #(
  parameter int unsigned CNT_W    = 20,
  parameter int unsigned TICK_CYC = `ACAL_TICK_CYC,
  parameter int unsigned CAL0_US  = `ACAL_CAL0_MS * `ACAL_US_PER_MS,
  parameter int unsigned CAL1_US  = `ACAL_CAL1_MS * `ACAL_US_PER_MS,
  parameter int unsigned CAL2_US  = `ACAL_CAL2_MS * `ACAL_US_PER_MS,
  parameter int unsigned MEAS_US  = `ACAL_MEAS_MS * `ACAL_US_PER_MS,
  parameter int unsigned ZC0_US   = `ACAL_ZC0_US,
  parameter int unsigned ZC1_US   = `ACAL_ZC1_US,
  parameter int unsigned ZC2_US   = `ACAL_ZC2_US,
  parameter int unsigned ZC3_US   = `ACAL_ZC3_US
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Pins from outside the clock domain
  input  wire logic       ext_trig_in,
  input  wire logic       dev_en_in,
  // Crossing detector handshake, same clock
  input  wire logic       zc_start_in,
  output logic            zc_window_out,
  // Calibration status towards the driver
  output logic            cal_run_out,
  output logic            cal_meas_out,
  output logic            cal_done_out,
  output logic      [1:0] cal_dur_sel_out,
  output logic      [1:0] crossing_detect_window_sel_out
);
  import acal_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rstn_q;

  // Assert at once, release after two edges
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rstn_q     <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q     <= rst_meta_q;
    end
  end

  // ==========================================================
  // State and timers
  acal_state_t      st_q;
  acal_state_t      st_d;
  logic             cal_ld;
  logic [CNT_W-1:0] cal_val;
  logic             cal_exp;
  logic             zc_ld;
  logic [CNT_W-1:0] zc_val;
  logic             zc_busy;

  // Register strobe decode
  logic wr_dur;
  logic wr_zc;
  logic wr_ctrl;
  logic go_wr;
  logic done_clr;
  logic trig_rise;
  logic en_fall;
  logic start_req;
  logic cancel_req;

  // Duration code to microsecond ticks
  function automatic logic [CNT_W-1:0] cal_us(input logic [1:0] sel);
    logic [CNT_W-1:0] v;
    v = CNT_W'(CAL2_US);
    case (sel)
      2'h0: v = CNT_W'(CAL0_US);
      2'h1: v = CNT_W'(CAL1_US);
      default: v = CNT_W'(CAL2_US);
    endcase
    return v;
  endfunction

  // Crossing window code to microsecond ticks
  function automatic logic [CNT_W-1:0] zc_us(input logic [1:0] sel);
    logic [CNT_W-1:0] v;
    v = CNT_W'(ZC0_US);
    case (sel)
      2'h0: v = CNT_W'(ZC0_US);
      2'h1: v = CNT_W'(ZC1_US);
      2'h2: v = CNT_W'(ZC2_US);
      default: v = CNT_W'(ZC3_US);
    endcase
    return v;
  endfunction

  // Write decode
  always_comb begin
    wr_dur  = 1'b0;
    wr_zc   = 1'b0;
    wr_ctrl = 1'b0;
    if (reg_wr_in && reg_addr_in == `ACAL_OFS_DUR) begin
      wr_dur = 1'b1;
    end else if (reg_wr_in && reg_addr_in == `ACAL_OFS_ZC) begin
      wr_zc = 1'b1;
    end else if (reg_wr_in && reg_addr_in == `ACAL_OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end
  end

  assign go_wr    = wr_ctrl && reg_wdata_in[`ACAL_CTRL_GO];
  assign done_clr = wr_ctrl && reg_wdata_in[`ACAL_CTRL_DONE];

  // Filtered pin edges, from the second and third stages and the held level;
  // worked out from registered stages so no loop through st_d
  assign trig_rise = (st_q.trig_s[1] == st_q.trig_s[2]) && st_q.trig_s[2]
                     && !st_q.trig_l;
  assign en_fall   = (st_q.en_s[1] == st_q.en_s[2]) && !st_q.en_s[2]
                     && st_q.en_l;

  // Run starts from software or the external trigger while enabled
  assign start_req = (st_q.phase == ACAL_IDLE) && st_q.en_l
                     && (go_wr || trig_rise);

  // Any of the three triggers ends a manual run
  assign cancel_req = (st_q.phase == ACAL_RUN) && st_q.manual
                      && (go_wr || trig_rise || en_fall);

  // ==========================================================
  // Next state
  always_comb begin
    st_d    = st_q;
    cal_ld  = 1'b0;
    cal_val = '0;
    zc_ld   = 1'b0;
    zc_val  = zc_us(st_q.zc);

    // Pin synchronisers; a level changes once stages two and three agree
    st_d.trig_s = {st_q.trig_s[1:0], ext_trig_in};
    st_d.en_s   = {st_q.en_s[1:0], dev_en_in};
    if (st_q.trig_s[1] == st_q.trig_s[2]) begin
      st_d.trig_l = st_q.trig_s[2];
    end
    if (st_q.en_s[1] == st_q.en_s[2]) begin
      st_d.en_l = st_q.en_s[2];
    end

    // Microsecond tick divider
    st_d.tick = 1'b0;
    if (st_q.div >= 16'(TICK_CYC - 1)) begin
      st_d.div  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 16'h0001;
    end

    // Configuration writes
    if (wr_dur) begin
      st_d.dur = reg_wdata_in[`ACAL_SEL_LSB +: 2];
    end
    if (wr_zc) begin
      st_d.zc = reg_wdata_in[`ACAL_SEL_LSB +: 2];
    end

    // Software clear of the done flag; a new completion wins below
    if (done_clr) begin
      st_d.done = 1'b0;
    end

    // Calibration sequence
    case (st_q.phase)
      ACAL_IDLE: begin
        if (start_req) begin
          st_d.phase  = ACAL_RUN;
          st_d.manual = (st_q.dur == `ACAL_DUR_MANUAL);
          if (st_q.dur != `ACAL_DUR_MANUAL) begin
            cal_ld  = 1'b1;
            cal_val = cal_us(st_q.dur);
          end
        end
      end
      ACAL_RUN: begin
        if ((!st_q.manual && cal_exp) || cancel_req) begin
          st_d.phase = ACAL_MEAS;
          cal_ld     = 1'b1;
          cal_val    = CNT_W'(MEAS_US);
        end
      end
      ACAL_MEAS: begin
        if (cal_exp) begin
          st_d.phase = ACAL_IDLE;
          st_d.done  = 1'b1;
        end
      end
      default: begin
        st_d.phase = ACAL_IDLE;
      end
    endcase

    // Crossing window opens on each detector request
    if (zc_start_in) begin
      zc_ld = 1'b1;
    end

    // Registered read data, unmapped offsets read zero
    if (reg_rd_in) begin
      if (reg_addr_in == `ACAL_OFS_DUR) begin
        st_d.rdata = {6'h00, st_q.dur};
      end else if (reg_addr_in == `ACAL_OFS_ZC) begin
        st_d.rdata = {6'h00, st_q.zc};
      end else if (reg_addr_in == `ACAL_OFS_CTRL) begin
        st_d.rdata = {3'h0, st_q.manual,
                      st_q.phase == ACAL_MEAS,
                      st_q.phase == ACAL_RUN,
                      st_q.done, 1'b0};
      end else begin
        st_d.rdata = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rstn_q) begin
    if (!rstn_q) begin
      st_q       <= '0;
      st_q.phase <= ACAL_IDLE;
      st_q.dur   <= `ACAL_DUR_RST;
      st_q.zc    <= `ACAL_ZC_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Timers
  acal_tick_timer #(
    .CNT_W       (CNT_W)
  ) u_cal_timer (
    .clk_in      (sys_clk_in),
    .rstn_in     (rstn_q),
    .tick_in     (st_q.tick),
    .load_in     (cal_ld),
    .load_val_in (cal_val),
    .busy_out    (),
    .expire_out  (cal_exp)
  );

  acal_tick_timer #(
    .CNT_W       (CNT_W)
  ) u_zc_timer (
    .clk_in      (sys_clk_in),
    .rstn_in     (rstn_q),
    .tick_in     (st_q.tick),
    .load_in     (zc_ld),
    .load_val_in (zc_val),
    .busy_out    (zc_busy),
    .expire_out  ()
  );

  // ==========================================================
  // Outputs
  assign reg_rdata_out                  = st_q.rdata;
  assign zc_window_out                  = zc_busy;
  assign cal_run_out                    = (st_q.phase == ACAL_RUN);
  assign cal_meas_out                   = (st_q.phase == ACAL_MEAS);
  assign cal_done_out                   = st_q.done;
  assign cal_dur_sel_out                = st_q.dur;
  assign crossing_detect_window_sel_out = st_q.zc;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_q);

  // Timed start loads the selected duration
  a_timed_load_value: assert property (
    (start_req && st_q.dur != `ACAL_DUR_MANUAL)
      |-> (cal_ld && cal_val == cal_us(st_q.dur))
      ##1 (st_q.phase == ACAL_RUN && !st_q.manual)
  ) else $error("timed run not loaded with selected duration");

  // Timer expiry ends a timed run
  a_timed_run_end: assert property (
    (st_q.phase == ACAL_RUN && !st_q.manual && cal_exp)
      |=> (st_q.phase == ACAL_MEAS)
  ) else $error("timed run did not end on expiry");

  // Manual run holds until a trigger
  a_manual_run_hold: assert property (
    (st_q.phase == ACAL_RUN && st_q.manual && !cancel_req)
      |=> (st_q.phase == ACAL_RUN)
  ) else $error("manual run ended without trigger");

  // Cancellation leads to measurement, then completion
  a_cancel_to_meas: assert property (
    cancel_req |=> (st_q.phase == ACAL_MEAS)
  ) else $error("cancel did not start measurement");

  a_meas_completes: assert property (
    (st_q.phase == ACAL_MEAS && cal_exp)
      |=> (st_q.phase == ACAL_IDLE && st_q.done)
  ) else $error("measurement did not complete");

  // Crossing window loads the selected time and opens next cycle
  a_zc_window_open: assert property (
    zc_start_in |-> (zc_val == zc_us(st_q.zc)) ##1 zc_window_out
  ) else $error("crossing window not opened with selected time");

  // Duration selector reads code 2 after reset
  a_dur_after_reset: assert property (
    $rose(rstn_q) |-> (st_q.dur == `ACAL_DUR_RST)
  ) else $error("duration selector not at reset code");

endmodule

// ===== testbench/acal_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host side: drives trigger and enable pins, cancels manual runs
module acal_host_model #(
  parameter int MIN_CYC = 50
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Requests from the bench
  input  wire logic cal_run_in,
  input  wire logic trig_req_in,
  input  wire logic dis_req_in,
  // Pins
  output logic      ext_trig_out,
  output logic      dev_en_out
);
  logic [15:0] age_q;
  logic [3:0]  hold_q;
  logic        kind_q;
  logic        pend_q;

  // Holds a cancel back until the run is old enough
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      age_q  <= 16'h0;
      hold_q <= 4'h0;
      kind_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      age_q <= cal_run_in ? age_q + 16'h1 : 16'h0;
      if (trig_req_in || dis_req_in) begin
        pend_q <= 1'b1;
        kind_q <= dis_req_in;
      end
      if (pend_q && age_q >= MIN_CYC) begin
        pend_q <= 1'b0;
        hold_q <= 4'h8;
      end else if (hold_q != 4'h0) begin
        hold_q <= hold_q - 4'h1;
      end
    end
  end

  // Pin levels follow the pulse in progress
  assign ext_trig_out = !kind_q && hold_q != 4'h0;
  assign dev_en_out   = !(kind_q && hold_q != 4'h0);
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the calibration timing block
module testbench;
  import acal_pkg::*;
  localparam int T = 2;
  localparam int M = 3;
  localparam int C0 = 5;
  localparam int C1 = 10;
  localparam int C2 = 20;
  localparam int Z0 = 2;
  localparam int Z1 = 3;
  localparam int Z2 = 4;
  localparam int Z3 = 5;
  localparam int CAL [3] = '{C0, C1, C2};
  localparam int ZC [4] = '{Z0, Z1, Z2, Z3};
  logic       clk, rstn, wr, rd, zc_start, trig_req, dis_req;
  logic [7:0] addr, wdata, rdata;
  logic       ext_trig, dev_en, zc_win, run, meas, done;
  logic [1:0] dur_sel, win_sel;
  logic [15:0] lfsr, v;
  int bad_count, compares, rc, mc, zcc, k;
  logic rd_p;
  logic [15:0] rd_q[$];
  int run_q[$], meas_q[$], zc_q[$];

  acal_top #(.TICK_CYC(T), .CAL0_US(C0), .CAL1_US(C1), .CAL2_US(C2),
    .MEAS_US(M), .ZC0_US(Z0), .ZC1_US(Z1), .ZC2_US(Z2),
    .ZC3_US(Z3)) acal_top_i (
    .sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .ext_trig_in(ext_trig), .dev_en_in(dev_en),
    .zc_start_in(zc_start), .zc_window_out(zc_win), .cal_run_out(run),
    .cal_meas_out(meas), .cal_done_out(done), .cal_dur_sel_out(dur_sel),
    .crossing_detect_window_sel_out(win_sel));

  acal_host_model acal_host_model_i (
    .clk_in(clk), .rstn_in(rstn), .cal_run_in(run),
    .trig_req_in(trig_req), .dis_req_in(dis_req),
    .ext_trig_out(ext_trig), .dev_en_out(dev_en));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Length in ticks if within one tick of n, else raw cycles
  function automatic int len_of(input int cnt, input int n);
    return (cnt >= (n - 1) * T && cnt <= (n + 1) * T + 1) ? n : cnt;
  endfunction

  function automatic logic [15:0] next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    rd_q.push_back({8'h0, e});
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  task automatic wait_done;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
  endtask

  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Monitor: read data and pulse lengths against the oldest note
  always @(negedge clk) begin
    if (rd_p) check(rdata, rd_q.pop_front());
    rd_p = rd;
    if (run) rc++;
    else begin
      if (rc > 0 && run_q.size() > 0) begin
        k = run_q.pop_front();
        check(len_of(rc, k), k);
      end
      rc = 0;
    end
    if (meas) mc++;
    else begin
      if (mc > 0) check(len_of(mc, M), meas_q.pop_front());
      mc = 0;
    end
    if (zc_win) zcc++;
    else begin
      if (zcc > 0) begin
        k = zc_q.pop_front();
        check(len_of(zcc, k), k);
      end
      zcc = 0;
    end
  end

  // Watchdog
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    {wr, rd, zc_start, trig_req, dis_req, rd_p} = 6'h0;
    addr = 8'h0;
    wdata = 8'h0;
    rstn = 1'b0;
    lfsr = 16'hbcc8;
    bad_count = 0;
    compares = 0;
    rc = 0;
    mc = 0;
    zcc = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    check(dur_sel, 2'h2);
    rd_reg(8'h2a, 8'h02);
    rd_reg(8'h29, 8'h00);
    wr_reg(8'h40, 8'hff);
    rd_reg(8'h40, 8'h00);
    // Random register traffic, reserved bits read back zero
    for (int i = 0; i < 4; i++) begin
      lfsr = next(lfsr);
      v = lfsr;
      wr_reg(8'h29, v[7:0]);
      rd_reg(8'h29, {6'h0, v[1:0]});
      wr_reg(8'h2a, v[15:8]);
      rd_reg(8'h2a, {6'h0, v[9:8]});
      check(win_sel, v[1:0]);
    end
    // Every window code
    for (int j = 0; j < 4; j++) begin
      wr_reg(8'h29, j[7:0]);
      zc_q.push_back(ZC[j]);
      @(posedge clk);
      zc_start <= 1'b1;
      @(posedge clk);
      zc_start <= 1'b0;
      repeat (15) @(posedge clk);
    end
    // Timed runs; a go in mid-run must not cut them short
    for (int j = 0; j < 3; j++) begin
      wr_reg(8'h2a, j[7:0]);
      @(negedge clk);
      check(dur_sel, j[1:0]);
      run_q.push_back(CAL[j]);
      meas_q.push_back(M);
      wr_reg(8'h2b, 8'h01);
      rd_reg(8'h2b, 8'h04);
      repeat (4) @(posedge clk);
      wr_reg(8'h2b, 8'h01);
      wait_done();
      check(done, 1'b1);
      rd_reg(8'h2b, 8'h02);
      wr_reg(8'h2b, 8'h02);
      repeat (2) @(posedge clk);
      check(done, 1'b0);
    end
    // Manual runs ended by trigger, enable fall and go write
    for (int j = 0; j < 3; j++) begin
      wr_reg(8'h2a, 8'h03);
      meas_q.push_back(M);
      wr_reg(8'h2b, 8'h01);
      repeat (48) @(posedge clk);
      check(run, 1'b1);
      rd_reg(8'h2b, 8'h14);
      if (j == 2) begin
        repeat (10) @(posedge clk);
        wr_reg(8'h2b, 8'h01);
      end else begin
        trig_req <= (j == 0);
        dis_req  <= (j == 1);
        @(posedge clk);
        trig_req <= 1'b0;
        dis_req  <= 1'b0;
      end
      wait_done();
      check(done, 1'b1);
      wr_reg(8'h2b, 8'h02);
      repeat (20) @(posedge clk);
    end
    finish_test();
  end
endmodule
